// ===== inc/tpcg_consts.svh
`ifndef TPCG_CONSTS_SVH
`define TPCG_CONSTS_SVH

// ********************************************************
// Clock and timing
// ********************************************************
`define TPCG_CLK_PERIOD_NS   25
`define TPCG_SYNC_STAGES     2
`define TPCG_DEADBAND_MAX    128
`define TPCG_DB_W            8

// ********************************************************
// Operating mode codes
// ********************************************************
`define TPCG_MODE_PWM_SINGLE 4'h3
`define TPCG_MODE_CAPTURE    4'h4
`define TPCG_MODE_COMPARE    4'h5
`define TPCG_MODE_GATED      4'h6
`define TPCG_MODE_CAP_CMP    4'h7
`define TPCG_MODE_PWM_DUAL   4'h8
`define TPCG_MODE_CAP_RST    4'h9

// ********************************************************
// Interrupt source select codes
// ********************************************************
`define TPCG_ICFG_EVT_ONLY   2'h2
`define TPCG_ICFG_RLD_ONLY   2'h3

// ********************************************************
// Reset and restart values
// ********************************************************
`define TPCG_COUNT_RESTART   16'h0001
`define TPCG_COUNT_RESET     16'h0001
`define TPCG_RELOAD_RESET    16'hFFFF
`define TPCG_MATCH_RESET     16'h0000
`define TPCG_COUNT_MAX       16'hFFFF

`endif

// ===== inc/tpcg_pkg.sv
`include "tpcg_consts.svh"

package tpcg_pkg;

	// ********************************************************
	// Operating modes
	// ********************************************************
	typedef enum logic [3:0] {
		TPCG_PWM_SINGLE = `TPCG_MODE_PWM_SINGLE,
		TPCG_CAPTURE    = `TPCG_MODE_CAPTURE,
		TPCG_COMPARE    = `TPCG_MODE_COMPARE,
		TPCG_GATED      = `TPCG_MODE_GATED,
		TPCG_CAP_CMP    = `TPCG_MODE_CAP_CMP,
		TPCG_PWM_DUAL   = `TPCG_MODE_PWM_DUAL,
		TPCG_CAP_RST    = `TPCG_MODE_CAP_RST
	} tpcg_mode_type;

	// ********************************************************
	// Run state
	// ********************************************************
	typedef enum logic [2:0] {
		TPCG_ST_OFF  = 3'b001,
		TPCG_ST_WAIT = 3'b010,
		TPCG_ST_RUN  = 3'b100
	} tpcg_state_type;

endpackage

// ===== inc/tpcg_pwm_if.sv
`timescale 1ns/1ps

interface tpcg_pwm_if;
	logic       level;
	logic       dual;
	logic [2:0] delay_sel;

	modport src (output level, output dual, output delay_sel);
	modport drv (input level, input dual, input delay_sel);
endinterface

// ===== src/tpcg_deadband.sv
`timescale 1ns/1ps

module tpcg_deadband (
	input  wire logic              clk,
	input  wire logic              reset,
	tpcg_pwm_if.drv                pwm,
	output logic                   timer_output,
	output logic                   timer_output_complement
);

	logic [`TPCG_DB_W-1:0] wait_q;
	logic                  last_q;
	logic [`TPCG_DB_W-1:0] delay_cycles;

	// ********************************************************
	// Deadband length, zero or a power of two up to 128
	// ********************************************************
	always_comb begin
		if (pwm.delay_sel == 3'h0) begin
			delay_cycles = 8'h00;
		end else begin
			delay_cycles = 8'h01 << pwm.delay_sel;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			last_q <= 1'b0;
		end else begin
			last_q <= pwm.level;
		end
	end

	// ********************************************************
	// Output pair
	// ********************************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wait_q                  <= 8'h00;
			timer_output            <= 1'b0;
			timer_output_complement <= 1'b0;
		end else if (!pwm.dual) begin
			wait_q                  <= 8'h00;
			timer_output            <= pwm.level;
			timer_output_complement <= 1'b0;
		end else if (pwm.level != last_q && delay_cycles != 8'h00) begin
			wait_q                  <= delay_cycles; // [RQ5]
			timer_output            <= 1'b0;
			timer_output_complement <= 1'b0;
		end else if (wait_q > 8'h01) begin
			wait_q <= wait_q - 8'h01;
		end else begin
			wait_q                  <= 8'h00;
			timer_output            <= last_q;
			timer_output_complement <= ~last_q; // [RQ4]
		end
	end

endmodule // tpcg_deadband

// ===== src/tpcg_timer.sv
`timescale 1ns/1ps

// Overview of operation
// [RQ1] PWM toggles output when count equals match
// [RQ2] PWM reload interrupts, restarts count at 0001h
// [RQ3] PWM output starts polarity, inverts at match
// [RQ4] Dual mode drives complement of PWM output
// [RQ5] Deadband delays each inactive-to-active edge
// [RQ6] Software keeps reload above match value
// [RQ7] Starting count affects first pass only
// [RQ8] Polarity one gives high ratio match/reload
// [RQ9] Capture copies count into match storage
// [RQ10] Capture modes select capture/reload interrupt sources
// [RQ11] Cause flag: set capture, clear reload
// [RQ12] Input synchronised, two to three cycles
// [RQ13] Capture modes toggle output at reload
// [RQ14] Plain capture wraps, never restarts count
// [RQ15] Capture restart: first event restarts count
// [RQ16] Capture/compare starts at first input edge
// [RQ17] Compare interrupts and toggles, no restart
// [RQ18] Compare mode wraps FFFFh to 0000h
// [RQ19] Gated counts only while input active
// [RQ20] Gated interrupts on deassert, reload, both
// [RQ21] Gated reload restarts count, toggles output
// [RQ22] Software enables last after configuring
// [RQ23] Four-bit operating mode code
// [RQ24] Non-capture interrupt select decode
// [RQ25] Count advances on each prescaler tick

module tpcg_timer (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        timer_enable,
	input  wire logic [3:0]  operating_mode_code,
	input  wire logic        polarity_select_bit,
	input  wire logic [1:0]  interrupt_source_select,
	input  wire logic [2:0]  deadband_delay_field,
	input  wire logic [2:0]  prescale_select,
	input  wire logic        output_function_enable,
	input  wire logic        count_write,
	input  wire logic [15:0] count_write_value,
	input  wire logic        match_write,
	input  wire logic [15:0] match_write_value,
	input  wire logic [15:0] reload_value,
	input  wire logic        timer_input,
	output logic [15:0]      count_value_q,
	output logic [15:0]      match_value_q,
	output logic             capture_cause_flag,
	output logic             timer_irq_q,
	output logic             timer_output,
	output logic             timer_output_complement
);

	tpcg_pwm_if pwm_link ();

	tpcg_pkg::tpcg_mode_type  mode;
	tpcg_pkg::tpcg_state_type state_q;
	tpcg_pkg::tpcg_state_type state_d;

	logic        in_s1_q;
	logic        in_s2_q;
	logic        in_s3_q;
	logic [6:0]  presc_q;
	logic [6:0]  presc_limit;
	logic        tick;
	logic        is_pwm;
	logic        is_capture;
	logic        restarts;
	logic        in_active;
	logic        edge_sel;
	logic        deassert;
	logic        capture_evt;
	logic        at_reload;
	logic        reload_evt;
	logic        event_irq;
	logic        reload_irq;
	logic        level_q;
	logic        flag_q;
	logic [15:0] count_next;

	assign mode = tpcg_pkg::tpcg_mode_type'(operating_mode_code); // [RQ23]

	// ********************************************************
	// Mode classes
	// ********************************************************
	always_comb begin
		is_pwm     = 1'b0;
		is_capture = 1'b0;
		restarts   = 1'b0;
		unique case (mode)
			tpcg_pkg::TPCG_PWM_SINGLE,
			tpcg_pkg::TPCG_PWM_DUAL: begin
				is_pwm   = 1'b1;
				restarts = 1'b1;
			end
			tpcg_pkg::TPCG_CAPTURE: begin
				is_capture = 1'b1;
			end
			tpcg_pkg::TPCG_CAP_RST,
			tpcg_pkg::TPCG_CAP_CMP: begin
				is_capture = 1'b1;
				restarts   = 1'b1;
			end
			tpcg_pkg::TPCG_GATED: begin
				restarts = 1'b1;
			end
			tpcg_pkg::TPCG_COMPARE: begin
				restarts = 1'b0;
			end
			default: begin
				restarts = 1'b0;
			end
		endcase
	end

	// ********************************************************
	// Input synchroniser
	// ********************************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			in_s1_q <= 1'b0;
			in_s2_q <= 1'b0;
			in_s3_q <= 1'b0;
		end else begin
			in_s1_q <= timer_input;
			in_s2_q <= in_s1_q; // [RQ12]
			in_s3_q <= in_s2_q;
		end
	end

	assign in_active = (in_s2_q == polarity_select_bit); // [RQ19]
	assign edge_sel  = (in_s2_q != in_s3_q) && in_active; // [RQ9]
	assign deassert  = (in_s3_q == polarity_select_bit) && !in_active;

	// ********************************************************
	// Prescaler
	// ********************************************************
	assign presc_limit = 7'((8'h01 << prescale_select) - 8'h01);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			presc_q <= 7'h00;
		end else if (state_q != tpcg_pkg::TPCG_ST_RUN || tick) begin
			presc_q <= 7'h00;
		end else if (mode != tpcg_pkg::TPCG_GATED || in_active) begin
			presc_q <= presc_q + 7'h01;
		end
	end

	always_comb begin
		tick = 1'b0;
		if (state_q == tpcg_pkg::TPCG_ST_RUN && presc_q == presc_limit) begin
			tick = (mode != tpcg_pkg::TPCG_GATED) || in_active; // [RQ25]
		end
	end

	// ********************************************************
	// Run state
	// ********************************************************
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			tpcg_pkg::TPCG_ST_OFF: begin
				if (timer_enable) begin
					if (mode == tpcg_pkg::TPCG_CAP_CMP) begin
						state_d = tpcg_pkg::TPCG_ST_WAIT;
					end else begin
						state_d = tpcg_pkg::TPCG_ST_RUN;
					end
				end
			end
			tpcg_pkg::TPCG_ST_WAIT: begin
				if (!timer_enable) begin
					state_d = tpcg_pkg::TPCG_ST_OFF;
				end else if (edge_sel) begin
					state_d = tpcg_pkg::TPCG_ST_RUN; // [RQ16]
				end
			end
			tpcg_pkg::TPCG_ST_RUN: begin
				if (!timer_enable) begin
					state_d = tpcg_pkg::TPCG_ST_OFF;
				end
			end
			default: begin
				state_d = tpcg_pkg::TPCG_ST_OFF;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q <= tpcg_pkg::TPCG_ST_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// ********************************************************
	// Events
	// ********************************************************
	assign capture_evt = is_capture && edge_sel && state_q == tpcg_pkg::TPCG_ST_RUN;
	assign at_reload   = (count_value_q == reload_value);
	assign reload_evt  = tick && at_reload;
	assign count_next  = count_value_q + 16'h0001;

	// ********************************************************
	// Interrupt source selection
	// ********************************************************
	always_comb begin
		event_irq  = 1'b0;
		reload_irq = 1'b0;
		if (is_capture || mode == tpcg_pkg::TPCG_GATED) begin
			if (interrupt_source_select != `TPCG_ICFG_RLD_ONLY) begin
				event_irq = is_capture ? capture_evt
					: (deassert && state_q == tpcg_pkg::TPCG_ST_RUN); // [RQ10] [RQ20]
			end
			if (interrupt_source_select != `TPCG_ICFG_EVT_ONLY) begin
				reload_irq = reload_evt;
			end
		end else if (interrupt_source_select != `TPCG_ICFG_EVT_ONLY) begin
			reload_irq = reload_evt; // [RQ24]
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			timer_irq_q <= 1'b0;
		end else begin
			timer_irq_q <= event_irq || reload_irq; // [RQ2] [RQ17]
		end
	end

	// ********************************************************
	// Cause flag
	// ********************************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			flag_q <= 1'b0;
		end else if (is_capture && event_irq) begin
			flag_q <= 1'b1; // [RQ11]
		end else if (is_capture && reload_irq) begin
			flag_q <= 1'b0; // [RQ11]
		end
	end

	assign capture_cause_flag = flag_q;

	// ********************************************************
	// Counter
	// ********************************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			count_value_q <= `TPCG_COUNT_RESET;
		end else if (count_write) begin
			count_value_q <= count_write_value; // [RQ7]
		end else if (capture_evt && restarts) begin
			count_value_q <= `TPCG_COUNT_RESTART; // [RQ15] [RQ16]
		end else if (reload_evt && restarts) begin
			count_value_q <= `TPCG_COUNT_RESTART; // [RQ2] [RQ7] [RQ21]
		end else if (tick) begin
			count_value_q <= count_next; // [RQ14] [RQ18]
		end
	end

	// ********************************************************
	// Match and capture storage
	// ********************************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			match_value_q <= `TPCG_MATCH_RESET;
		end else if (capture_evt) begin
			match_value_q <= count_value_q; // [RQ9] [RQ14]
		end else if (match_write) begin
			match_value_q <= match_write_value;
		end
	end

	// ********************************************************
	// Output level
	// ********************************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			level_q <= 1'b0;
		end else if (state_q == tpcg_pkg::TPCG_ST_OFF) begin
			level_q <= polarity_select_bit; // [RQ3] [RQ13]
		end else if (is_pwm) begin
			if (reload_evt) begin
				level_q <= polarity_select_bit; // [RQ3] [RQ8]
			end else if (tick && count_value_q == match_value_q) begin
				level_q <= ~polarity_select_bit; // [RQ1] [RQ8]
			end
		end else if (reload_evt && output_function_enable) begin
			level_q <= ~level_q; // [RQ13] [RQ17] [RQ21]
		end
	end

	// ********************************************************
	// Pin drivers
	// ********************************************************
	assign pwm_link.level     = level_q;
	assign pwm_link.dual      = (mode == tpcg_pkg::TPCG_PWM_DUAL); // [RQ4]
	assign pwm_link.delay_sel = deadband_delay_field;

	tpcg_deadband u_deadband (
		.clk                     (clk),
		.reset                   (reset),
		.pwm                     (pwm_link),
		.timer_output            (timer_output),
		.timer_output_complement (timer_output_complement)
	);

endmodule // tpcg_timer

// ===== testbench/tpcg_in_src.sv
`timescale 1ns/1ps
module tpcg_in_src (
	input  wire logic level_req,
	output logic      timer_input
);
	// ********
	// Input source, edges land off the clock edge
	// ********
	initial timer_input = 1'b0;
	always @(level_req) timer_input <= #3 level_req;
endmodule // tpcg_in_src

// ===== testbench/tpcg_timer_props.sv
`timescale 1ns/1ps
module tpcg_timer_props (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        timer_enable,
	input wire logic [3:0]  operating_mode_code,
	input wire logic        polarity_select_bit,
	input wire logic [1:0]  interrupt_source_select,
	input wire logic [2:0]  deadband_delay_field,
	input wire logic [2:0]  prescale_select,
	input wire logic        output_function_enable,
	input wire logic        count_write,
	input wire logic [15:0] count_write_value,
	input wire logic        match_write,
	input wire logic [15:0] match_write_value,
	input wire logic [15:0] reload_value,
	input wire logic        timer_input,
	input wire logic [15:0] count_value_q,
	input wire logic [15:0] match_value_q,
	input wire logic        capture_cause_flag,
	input wire logic        timer_irq_q,
	input wire logic        timer_output,
	input wire logic        timer_output_complement
);
	// ********
	// Helpers and properties
	// ********
	logic       en_q;
	logic [3:0] m_q;
	logic [4:0] off_q;
	logic       run;
	logic       pwm;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			en_q  <= 1'b0;
			m_q   <= 4'h0;
			off_q <= 5'h00;
		end else begin
			en_q  <= timer_enable;
			m_q   <= operating_mode_code;
			off_q <= {off_q[3:0], timer_input != polarity_select_bit};
		end
	end
	assign run = timer_enable && en_q && m_q == operating_mode_code && prescale_select == 3'h0 && !count_write;
	assign pwm = m_q == 4'h3 || m_q == 4'h8;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	cnt_free_a: assert property (run && (m_q == 4'h4 || m_q == 4'h5)
		|=> count_value_q == $past(count_value_q) + 16'h0001) else $error("free count broken");
	pwm_restart_a: assert property (run && pwm && count_value_q == reload_value
		|=> count_value_q == 16'h0001) else $error("pwm no restart");
	pwm_irq_a: assert property (run && pwm && count_value_q == reload_value && interrupt_source_select != 2'h2
		|-> ##[1:2] timer_irq_q) else $error("pwm irq missing");
	irq_off_a: assert property (en_q && (pwm || m_q == 4'h5) && m_q == operating_mode_code
		&& interrupt_source_select == 2'h2 && $past(interrupt_source_select) == 2'h2 |-> !timer_irq_q)
		else $error("irq while off");
	dual_excl_a: assert property (m_q == 4'h8 |-> !(timer_output && timer_output_complement))
		else $error("both outputs active");
	comp_idle_a: assert property (m_q != 4'h8 && $past(m_q) != 4'h8 |-> !timer_output_complement)
		else $error("complement outside dual");
	gate_hold_a: assert property (m_q == 4'h6 && $past(m_q) == 4'h6 && &off_q && !$past(count_write) |-> $stable(count_value_q))
		else $error("gated count moved");
	gate_reload_a: assert property (run && m_q == 4'h6 && off_q == 5'h00 && count_value_q == reload_value
		|=> count_value_q == 16'h0001) else $error("gated no restart");
	cap_irq_a: assert property (run && m_q == 4'h4 && polarity_select_bit && interrupt_source_select != 2'h3
		&& $rose(timer_input) |-> ##[2:5] timer_irq_q ##[0:1] capture_cause_flag) else $error("capture irq missing");
endmodule // tpcg_timer_props
bind tpcg_timer tpcg_timer_props u_props (.*);

// ===== testbench/tpcg_timer_tb.sv
`timescale 1ns/1ps
module tpcg_timer_tb;
	logic        clk = 1'b0, reset = 1'b1, timer_enable = 1'b0, polarity_select_bit = 1'b0;
	logic        output_function_enable = 1'b1, count_write = 1'b0, match_write = 1'b0, level_req = 1'b0;
	logic [3:0]  operating_mode_code = 4'h3;
	logic [2:0]  deadband_delay_field = 3'h0, prescale_select = 3'h0;
	logic [1:0]  interrupt_source_select = 2'h0;
	logic [15:0] count_write_value = 16'h0001, match_write_value = 16'h0000, reload_value = 16'hFFFF;
	logic [15:0] count_value_q, match_value_q, c0;
	logic        timer_input, capture_cause_flag, timer_irq_q, timer_output, timer_output_complement;
	int          mismatches = 0, check_count = 0, n, k;
	tpcg_timer u_dut (.*);
	tpcg_in_src u_src (.level_req(level_req), .timer_input(timer_input));
	always #12.5 clk = ~clk;
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cfg(input logic [3:0] m, input logic p, input logic [1:0] ic, input logic [15:0] c,
			input logic [15:0] mv, input logic [15:0] r);
		@(negedge clk);
		timer_enable = 1'b0;
		{operating_mode_code, polarity_select_bit, interrupt_source_select} = {m, p, ic};
		{level_req, reload_value, count_write_value, match_write_value} = {~p, r, c, mv};
		{count_write, match_write} = 2'h3;
		@(negedge clk);
		{count_write, match_write} = 2'h0;
		@(negedge clk);
		timer_enable = 1'b1;
	endtask
	task automatic wait_irq(output int cyc);
		cyc = 0;
		do begin
			@(negedge clk);
			cyc++;
		end while (timer_irq_q !== 1'b1 && cyc < 3000);
		if (cyc >= 3000) mismatches++;
	endtask
	task automatic t_pwm;
		cfg(4'h3, 1'b1, 2'h0, 16'h0008, 16'h0004, 16'h000A);
		wait_irq(n);
		chk(16'(n < 8), 16'h0001);
		wait_irq(n);
		chk(16'(n), 16'h000A);
		k = 0;
		repeat (20) begin
			@(negedge clk);
			k += timer_output;
		end
		chk(16'(k), 16'h0008);
		interrupt_source_select = 2'h2;
		k = 0;
		repeat (40) begin
			@(negedge clk);
			k += timer_irq_q;
		end
		chk(16'(k), 16'h0000);
		$display("pwm done");
	endtask
	task automatic t_dual;
		deadband_delay_field = 3'h2;
		cfg(4'h8, 1'b1, 2'h0, 16'h0001, 16'h0014, 16'h0028);
		wait_irq(n);
		k = 0;
		repeat (80) begin
			@(negedge clk);
			k += !timer_output && !timer_output_complement;
		end
		chk(16'(k), 16'h0010);
		deadband_delay_field = 3'h0;
		$display("dual done");
	endtask
	task automatic t_cap;
		cfg(4'h4, 1'b1, 2'h0, 16'h0100, 16'h0000, 16'hFFFF);
		repeat (20) @(negedge clk);
		c0 = count_value_q;
		level_req = 1'b1;
		wait_irq(n);
		@(negedge clk);
		c0 = match_value_q - c0;
		chk(16'(c0 == 16'h0002 || c0 == 16'h0003), 16'h0001);
		chk(16'(capture_cause_flag), 16'h0001);
		k = timer_output;
		reload_value = count_value_q + 16'h0010;
		wait_irq(n);
		repeat (2) @(negedge clk);
		chk(16'(capture_cause_flag), 16'h0000);
		chk(16'(count_value_q > reload_value), 16'h0001);
		chk(16'(timer_output), 16'(k == 0));
		$display("capture done");
	endtask
	task automatic t_cc;
		cfg(4'h7, 1'b1, 2'h0, 16'h0001, 16'h0000, 16'hFFFF);
		repeat (10) @(negedge clk);
		chk(count_value_q, 16'h0001);
		level_req = 1'b1;
		repeat (20) @(negedge clk);
		level_req = 1'b0;
		repeat (5) @(negedge clk);
		level_req = 1'b1;
		wait_irq(n);
		chk(16'(capture_cause_flag), 16'h0001);
		chk(16'(count_value_q < 16'h0004 && match_value_q > 16'h0018), 16'h0001);
		$display("capture compare done");
	endtask
	task automatic t_cmp;
		cfg(4'h5, 1'b0, 2'h0, 16'hFFF0, 16'h0000, 16'hFFF8);
		wait_irq(n);
		repeat (2) @(negedge clk);
		chk(16'(timer_output), 16'h0001);
		chk(16'(count_value_q > 16'hFFF8), 16'h0001);
		repeat (20) @(negedge clk);
		chk(16'(count_value_q < 16'h0020), 16'h0001);
		$display("compare done");
	endtask
	task automatic t_gate;
		cfg(4'h6, 1'b1, 2'h2, 16'h0001, 16'h0000, 16'h000C);
		repeat (10) @(negedge clk);
		chk(count_value_q, 16'h0001);
		level_req = 1'b1;
		repeat (30) @(negedge clk);
		level_req = 1'b0;
		wait_irq(n);
		chk(16'(n <= 6), 16'h0001);
		chk(16'(count_value_q > 16'h0001 && count_value_q <= 16'h000C), 16'h0001);
		$display("gated done");
	endtask
	initial begin
		repeat (12) @(negedge clk);
		reset = 1'b0;
		t_pwm;
		t_dual;
		t_cap;
		t_cc;
		t_cmp;
		t_gate;
		wrap_up;
	end
	initial begin
		#500000;
		mismatches++;
		wrap_up;
	end
endmodule // tpcg_timer_tb
